// *** src/otp_config_lock_and_discharge_ctrl.sv ***
// device end: volatile and nonvolatile config bytes, lockout, programming
// and power-down discharge sequencing
// assumes the link pins come from outside and are synchronised here
`timescale 1ns/100ps
`include "otp_ctrl_cfg.svh"

// Operation
// - discharge disabled: shut down at once
// - host sets discharge only with simultaneous order
// - discharge: converters off, discharge, wait, power down
// - near-ground comparators decide discharged outputs
// - fixed variant presets discharge and lock bits
// - locked: run only from nonvolatile bytes
// - locked: reads of bytes 0-2 return nonvolatile
// - locked: programming rejected, fault flag set
// - lock is bit 6 of nonvolatile byte two
// - lock bit reads true locked state always
// - programming copies selected volatile bytes only
// - select bit runs from volatile byte and marks it
// - supply first, write bit starts, clearing ends
// - command 50h sets switch-off, clears fault
// - 11h selects, 91h programs, 11h stops
// - stop command accepted with no wait
// - host checks fault after every byte
// - command 10h selects nonvolatile bytes, switches off
// - command 00h re-enables switches
// - host programs one byte at a time
// - host sets switch-off before programming
// - select bit zero nonvolatile, one volatile
// - shutdown or switch-off stops converters, ramps discharge
module otp_config_lock_and_discharge_ctrl
	import otp_ctrl_pkg::*;
#(
	parameter bit FIXED_OUTPUT = 1'b0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// link to the host
	otp_link_if.device link,
	// output comparators
	input wire logic posNearGnd,
	input wire logic negNearGnd,
	// converter control
	output logic convEnable,
	output logic dischargeOn,
	output logic rampDischarge,
	output logic poweredDown,
	// active configuration
	output byte_t cfgByte0,
	output byte_t cfgByte1,
	output byte_t cfgByte2,
	output logic locked
);

	// ----------------------------------------------------------------
	// selection helper
	// ----------------------------------------------------------------
	function automatic byte_t effByte(input logic sel, input logic lock,
		input byte_t vol, input byte_t nv);
		effByte = (lock || !sel) ? nv : vol;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	byte_t vol_ff [0:2];
	byte_t nv_ff [0:2];
	byte_t rdata_ff;
	byte_t eff0, eff1, eff2, rd2, rdMux;
	logic [3:0] pinMeta_ff, pinSync_ff;
	logic [2:0] sel_ff;
	logic write_nv_start_ff, switch_off_ff, fault_ff, ack_ff;
	logic convEnable_ff, dischargeOn_ff, rampDischarge_ff, poweredDown_ff;
	byte_t cfg0_ff, cfg1_ff, cfg2_ff;
	logic locked_ff;
	pdState_t pd_ff, nxt_pd;
	logic nxt_fault;
	localparam byte_t RESET_NV0 = FIXED_OUTPUT ? `FIXED_NV0 : `NV_BLANK;
	localparam byte_t RESET_NV1 = FIXED_OUTPUT ? `FIXED_NV1 : `NV_BLANK;
	localparam byte_t RESET_NV2 = FIXED_OUTPUT ? `FIXED_NV2 : `NV_BLANK;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire shutdown = !pinSync_ff[3];
	wire vppOk = pinSync_ff[2];
	wire posDone = pinSync_ff[1];
	wire negDone = pinSync_ff[0];
	wire lockNow = nv_ff[2][`CFG_LOCK_BIT];
	wire cmdWr = link.regWr && (link.regAddr == `ADDR_CMD);
	wire wotpStart = cmdWr && link.regWdata[`CMD_WRITE_NV_START_BIT] && !write_nv_start_ff;
	wire progReject = wotpStart && (lockNow || !vppOk);
	wire progDo = wotpStart && !progReject;
	wire faultClr = cmdWr && link.regWdata[`CMD_FAULT_BIT];
	wire [2:0] newSel = link.regWdata[`CMD_SEL_HI:0];
	wire bothDone = posDone && negDone;
	wire disEn = eff2[`CFG_DIS_BIT];
	wire swoffNext = cmdWr ? link.regWdata[`CMD_SWITCH_OFF_BIT] : switch_off_ff;

	assign eff0 = effByte(sel_ff[0], lockNow, vol_ff[0], nv_ff[0]);
	assign eff1 = effByte(sel_ff[1], lockNow, vol_ff[1], nv_ff[1]);
	assign eff2 = effByte(sel_ff[2], lockNow, vol_ff[2], nv_ff[2]);
	assign nxt_fault = progReject || (fault_ff && !faultClr);

	always_comb begin
		rd2 = eff2;
		rd2[`CFG_LOCK_BIT] = lockNow;
	end

	always_comb begin
		unique case (link.regAddr)
			`ADDR_BYTE0: rdMux = eff0;
			`ADDR_BYTE1: rdMux = eff1;
			`ADDR_BYTE2: rdMux = rd2;
			`ADDR_CMD: rdMux = {write_nv_start_ff, fault_ff, 1'b0, switch_off_ff, 1'b0,
				sel_ff};
			default: rdMux = `NV_BLANK;
		endcase
	end

	// ----------------------------------------------------------------
	// power-down sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_pd = pd_ff;
		unique case (pd_ff)
			PD_RUN: if (shutdown) begin
				nxt_pd = disEn ? PD_DISCHARGE : PD_OFF;
			end
			PD_DISCHARGE: if (bothDone) begin
				nxt_pd = PD_OFF;
			end
			PD_OFF: if (!shutdown) begin
				nxt_pd = PD_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		pinMeta_ff <= {link.shutdownN, link.vppOn, posNearGnd, negNearGnd};
		pinSync_ff <= pinMeta_ff;
	end

	// ----------------------------------------------------------------
	// registers and nonvolatile store
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 3; i++) begin
				vol_ff[i] <= `NV_BLANK;
			end
			nv_ff[0] <= RESET_NV0;
			nv_ff[1] <= RESET_NV1;
			nv_ff[2] <= RESET_NV2;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (link.regWr && link.regAddr == byte_t'(i)) begin
					vol_ff[i] <= link.regWdata;
				end
				if (progDo && newSel[i]) begin
					nv_ff[i] <= nv_ff[i] | vol_ff[i];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sel_ff <= 3'h0;
			write_nv_start_ff <= 1'b0;
			switch_off_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else begin
			if (cmdWr) begin
				sel_ff <= newSel;
				write_nv_start_ff <= link.regWdata[`CMD_WRITE_NV_START_BIT];
				switch_off_ff <= link.regWdata[`CMD_SWITCH_OFF_BIT];
			end
			fault_ff <= nxt_fault;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack_ff <= 1'b0;
			rdata_ff <= `NV_BLANK;
		end else begin
			ack_ff <= link.regWr || link.regRd;
			if (link.regRd) begin
				rdata_ff <= rdMux;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pd_ff <= PD_OFF;
			convEnable_ff <= 1'b0;
			dischargeOn_ff <= 1'b0;
			rampDischarge_ff <= 1'b1;
			poweredDown_ff <= 1'b1;
		end else begin
			pd_ff <= nxt_pd;
			convEnable_ff <= (nxt_pd == PD_RUN) && !swoffNext;
			dischargeOn_ff <= nxt_pd == PD_DISCHARGE;
			rampDischarge_ff <= shutdown || swoffNext;
			poweredDown_ff <= nxt_pd == PD_OFF;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg0_ff <= `NV_BLANK;
			cfg1_ff <= `NV_BLANK;
			cfg2_ff <= `NV_BLANK;
			locked_ff <= 1'b0;
		end else begin
			cfg0_ff <= eff0;
			cfg1_ff <= eff1;
			cfg2_ff <= eff2;
			locked_ff <= lockNow;
		end
	end

	assign link.regAck = ack_ff;
	assign link.regRdata = rdata_ff;
	assign convEnable = convEnable_ff;
	assign dischargeOn = dischargeOn_ff;
	assign rampDischarge = rampDischarge_ff;
	assign poweredDown = poweredDown_ff;
	assign cfgByte0 = cfg0_ff;
	assign cfgByte1 = cfg1_ff;
	assign cfgByte2 = cfg2_ff;
	assign locked = locked_ff;

endmodule

// *** src/otp_ctrl_cfg.svh ***
// constants for the configuration store, lockout and discharge logic
// assumes an 8-bit register port with a one-cycle acknowledge
`ifndef OTP_CTRL_CFG_SVH
`define OTP_CTRL_CFG_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_BYTE0 8'h00
`define ADDR_BYTE1 8'h01
`define ADDR_BYTE2 8'h02
`define ADDR_CMD 8'h04

// ----------------------------------------------------------------
// command register fields and commands
// ----------------------------------------------------------------
`define CMD_WRITE_NV_START_BIT 7
`define CMD_FAULT_BIT 6
`define CMD_SWITCH_OFF_BIT 4
`define CMD_SEL_HI 2
`define CMD_CLEAR_OFF 8'h50
`define CMD_SWITCH_OFF_ONLY 8'h10
`define CMD_WRITE_NV_START 8'h80
`define CMD_RUN 8'h00
`define SEL_ONE 8'h01

// ----------------------------------------------------------------
// configuration byte two fields
// ----------------------------------------------------------------
`define CFG_DIS_BIT 7
`define CFG_LOCK_BIT 6
`define CFG_ORDER_HI 5
`define CFG_ORDER_LO 4
`define ORDER_SIMUL 2'h3

// ----------------------------------------------------------------
// presets and thresholds
// ----------------------------------------------------------------
`define NV_BLANK 8'h00
`define FIXED_NV0 8'h00
`define FIXED_NV1 8'h00
`define FIXED_NV2 8'hF0
`define NEAR_GND_MIN_MV 500
`define NEAR_GND_MAX_MV 1500
`define PROG_LAST_STEP 3'h5

`endif

// *** src/otp_ctrl_pkg.sv ***
// types shared by both ends of the configuration link
// assumes otp_ctrl_cfg.svh holds the numeric constants
package otp_ctrl_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {PD_RUN, PD_DISCHARGE, PD_OFF} pdState_t;

	typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} hostState_t;

	typedef enum logic [1:0] {
		REQ_READ, REQ_WRITE, REQ_PROGRAM, REQ_NONE
	} reqKind_t;

endpackage

// *** src/otp_host_ctrl.sv ***
// host end: raw register access and a one-byte programming sequence
// assumes user requests arrive on ref_clk
`timescale 1ns/100ps
`include "otp_ctrl_cfg.svh"
module otp_host_ctrl
	import otp_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// user requests
	input wire logic reqValid,
	input wire reqKind_t reqKind,
	input wire byte_t reqAddr,
	input wire byte_t reqData,
	output logic reqReady,
	// user answers
	output logic rspValid,
	output byte_t rspData,
	output logic rspFault,
	// shutdown control
	input wire logic shutdownReq,
	// link to the device
	otp_link_if.host link
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic byte_t guardByte(input byte_t addr, input byte_t d);
		byte_t g;
		g = d;
		if (addr == `ADDR_BYTE2 &&
			d[`CFG_ORDER_HI:`CFG_ORDER_LO] != `ORDER_SIMUL) begin
			g[`CFG_DIS_BIT] = 1'b0;
		end
		return g;
	endfunction

	// one link operation: {write, address, data}
	function automatic logic [16:0] stepOp(input reqKind_t k,
		input logic [2:0] s, input byte_t a, input byte_t d);
		byte_t sel;
		sel = byte_t'(`SEL_ONE << a[1:0]);
		stepOp = {1'b0, a, `NV_BLANK};
		if (k == REQ_WRITE) begin
			stepOp = {1'b1, a, guardByte(a, d)};
		end else if (k == REQ_PROGRAM) begin
			unique case (s)
				3'h0: stepOp = {1'b1, `ADDR_CMD, `CMD_CLEAR_OFF};
				3'h1: stepOp = {1'b1, a, guardByte(a, d)};
				3'h2: stepOp = {1'b1, `ADDR_CMD, `CMD_SWITCH_OFF_ONLY | sel};
				3'h3: stepOp = {1'b1, `ADDR_CMD,
					`CMD_WRITE_NV_START | `CMD_SWITCH_OFF_ONLY | sel};
				3'h4: stepOp = {1'b1, `ADDR_CMD, `CMD_SWITCH_OFF_ONLY | sel};
				3'h5: stepOp = {1'b0, `ADDR_CMD, `NV_BLANK};
				default: stepOp = {1'b0, `ADDR_CMD, `NV_BLANK};
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	hostState_t st_ff, nxt_st;
	reqKind_t kind_ff;
	byte_t addr_ff, data_ff, rspData_ff, regAddr_ff, regWdata_ff;
	logic [2:0] step_ff, last_ff;
	logic regWr_ff, regRd_ff, vpp_ff, shutdown_n_ff;
	logic ready_ff, rspValid_ff, rspFault_ff;
	logic [16:0] op;

	wire accept = (st_ff == H_IDLE) && reqValid && (reqKind != REQ_NONE);
	wire finish = (st_ff == H_WAIT) && link.regAck && (step_ff == last_ff);
	assign op = stepOp(kind_ff, step_ff, addr_ff, data_ff);

	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			H_IDLE: if (accept) begin
				nxt_st = H_ISSUE;
			end
			H_ISSUE: nxt_st = H_WAIT;
			H_WAIT: if (link.regAck) begin
				nxt_st = finish ? H_IDLE : H_ISSUE;
			end
			default: nxt_st = H_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_ff <= H_IDLE;
			kind_ff <= REQ_READ;
			addr_ff <= `NV_BLANK;
			data_ff <= `NV_BLANK;
			step_ff <= 3'h0;
			last_ff <= 3'h0;
		end else begin
			st_ff <= nxt_st;
			if (accept) begin
				kind_ff <= reqKind;
				addr_ff <= reqAddr;
				data_ff <= reqData;
				step_ff <= 3'h0;
				last_ff <= (reqKind == REQ_PROGRAM) ? `PROG_LAST_STEP : 3'h0;
			end else if (st_ff == H_WAIT && link.regAck && !finish) begin
				step_ff <= step_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regWr_ff <= 1'b0;
			regRd_ff <= 1'b0;
			regAddr_ff <= `NV_BLANK;
			regWdata_ff <= `NV_BLANK;
		end else begin
			regWr_ff <= (st_ff == H_ISSUE) && op[16];
			regRd_ff <= (st_ff == H_ISSUE) && !op[16];
			regAddr_ff <= op[15:8];
			regWdata_ff <= op[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vpp_ff <= 1'b0;
			shutdown_n_ff <= 1'b0;
			ready_ff <= 1'b0;
			rspValid_ff <= 1'b0;
			rspData_ff <= `NV_BLANK;
			rspFault_ff <= 1'b0;
		end else begin
			if (accept) begin
				vpp_ff <= reqKind == REQ_PROGRAM;
			end else if (finish) begin
				vpp_ff <= 1'b0;
			end
			shutdown_n_ff <= !shutdownReq;
			ready_ff <= nxt_st == H_IDLE;
			rspValid_ff <= finish;
			if (finish) begin
				rspData_ff <= link.regRdata;
				rspFault_ff <= (kind_ff == REQ_PROGRAM) &&
					link.regRdata[`CMD_FAULT_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign link.regWr = regWr_ff;
	assign link.regRd = regRd_ff;
	assign link.regAddr = regAddr_ff;
	assign link.regWdata = regWdata_ff;
	assign link.vppOn = vpp_ff;
	assign link.shutdownN = shutdown_n_ff;
	assign reqReady = ready_ff;
	assign rspValid = rspValid_ff;
	assign rspData = rspData_ff;
	assign rspFault = rspFault_ff;

endmodule

// *** src/otp_link_if.sv ***
// register link between the configuring host and the converter logic
// assumes both ends run on ref_clk
`timescale 1ns/100ps
interface otp_link_if (
	input wire logic ref_clk
);
	import otp_ctrl_pkg::*;

	logic regWr;
	logic regRd;
	byte_t regAddr;
	byte_t regWdata;
	byte_t regRdata;
	logic regAck;
	logic shutdownN;
	logic vppOn;

	modport device (
		input regWr, regRd, regAddr, regWdata, shutdownN, vppOn,
		output regRdata, regAck
	);

	modport host (
		output regWr, regRd, regAddr, regWdata, shutdownN, vppOn,
		input regRdata, regAck
	);
endinterface

// *** testbench/otp_config_lock_and_discharge_ctrl_tb_top.sv ***
// bench top: host and device ends joined by the link
// assumes the package, header and interface under src are compiled first
`timescale 1ns/100ps
`include "otp_ctrl_cfg.svh"
module otp_config_lock_and_discharge_ctrl_tb_top
	import otp_ctrl_pkg::*;
;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reqValid = 1'b0;
	reqKind_t reqKind = REQ_NONE;
	byte_t reqAddr = 8'h00;
	byte_t reqData = 8'h00;
	logic shutdownReq = 1'b0;
	logic posNearGnd = 1'b0;
	logic negNearGnd = 1'b0;
	logic reqReady, rspValid, rspFault, locked;
	logic convEnable, dischargeOn, rampDischarge, poweredDown;
	byte_t rspData, cfgByte0, cfgByte1, cfgByte2;
	int failCount = 0;
	int compares = 0;

	always #2.5 ref_clk = ~ref_clk;

	otp_link_if link (.ref_clk(ref_clk));
	otp_host_ctrl u_otp_host_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr),
		.reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
		.rspData(rspData), .rspFault(rspFault),
		.shutdownReq(shutdownReq), .link(link.host));
	otp_config_lock_and_discharge_ctrl u_otp_config_lock_and_discharge_ctrl (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link.device),
		.posNearGnd(posNearGnd), .negNearGnd(negNearGnd),
		.convEnable(convEnable), .dischargeOn(dischargeOn),
		.rampDischarge(rampDischarge), .poweredDown(poweredDown),
		.cfgByte0(cfgByte0), .cfgByte1(cfgByte1), .cfgByte2(cfgByte2),
		.locked(locked));
	otp_link_chk u_otp_link_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.regWr(link.regWr), .regRd(link.regRd), .regAddr(link.regAddr),
		.regWdata(link.regWdata), .regRdata(link.regRdata),
		.regAck(link.regAck), .shutdownN(link.shutdownN),
		.vppOn(link.vppOn));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic finalReport();
		$display("compares %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input byte_t exp, input byte_t got);
		compares++;
		if (got !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic waitOut(input int n);
		failCount++;
		$display("[ERR] wait %0d expected answer seen none", n);
		finalReport();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic hostOp(input reqKind_t k, input byte_t a, input byte_t d);
		int n;
		n = 0;
		while (reqReady !== 1'b1) begin
			@(negedge ref_clk);
			n++;
			if (n > 50) waitOut(n);
		end
		@(posedge ref_clk);
		reqValid <= 1'b1;
		reqKind <= k;
		reqAddr <= a;
		reqData <= d;
		@(posedge ref_clk);
		reqValid <= 1'b0;
		n = 0;
		while (rspValid !== 1'b1) begin
			@(negedge ref_clk);
			n++;
			if (n > 60) waitOut(n);
		end
	endtask

	task automatic wr(input byte_t a, input byte_t d);
		hostOp(REQ_WRITE, a, d);
	endtask

	task automatic rdChk(input string what, input byte_t a, input byte_t exp);
		hostOp(REQ_READ, a, 8'h00);
		chk(what, exp, rspData);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testCommands();
		wr(`ADDR_CMD, `CMD_CLEAR_OFF);
		rdChk("cmd 50h", `ADDR_CMD, 8'h10);
		chk("conv off", 8'h00, byte_t'(convEnable));
		chk("ramp held", 8'h01, byte_t'(rampDischarge));
		wr(`ADDR_CMD, `CMD_SWITCH_OFF_ONLY);
		rdChk("cmd 10h", `ADDR_CMD, 8'h10);
		rdChk("unmapped", 8'h07, 8'h00);
		wr(`ADDR_CMD, `CMD_RUN);
		cyc(4);
		chk("conv on", 8'h01, byte_t'(convEnable));
		chk("ramp free", 8'h00, byte_t'(rampDischarge));
		$display("commands test done");
	endtask

	task automatic testProgram();
		wr(`ADDR_BYTE0, 8'hA5);
		wr(`ADDR_BYTE1, 8'h3C);
		rdChk("byte0 nv", `ADDR_BYTE0, 8'h00);
		wr(`ADDR_CMD, 8'h11);
		chk("active byte0", 8'hA5, cfgByte0);
		rdChk("byte0 reg", `ADDR_BYTE0, 8'hA5);
		hostOp(REQ_PROGRAM, `ADDR_BYTE0, 8'h5A);
		chk("prog fault", 8'h00, byte_t'(rspFault));
		wr(`ADDR_CMD, `CMD_SWITCH_OFF_ONLY);
		chk("nv byte0", 8'h5A, cfgByte0);
		chk("nv byte1", 8'h00, cfgByte1);
		$display("program test done");
	endtask

	task automatic testDischarge();
		wr(`ADDR_BYTE2, 8'hA0);
		wr(`ADDR_CMD, 8'h04);
		rdChk("dis guard", `ADDR_BYTE2, 8'h20);
		wr(`ADDR_BYTE2, 8'hB0);
		rdChk("dis kept", `ADDR_BYTE2, 8'hB0);
		@(posedge ref_clk);
		shutdownReq <= 1'b1;
		cyc(8);
		chk("discharging", 8'h01, byte_t'(dischargeOn));
		chk("conv stop", 8'h00, byte_t'(convEnable));
		chk("ramp shut", 8'h01, byte_t'(rampDischarge));
		@(posedge ref_clk);
		posNearGnd <= 1'b1;
		cyc(8);
		chk("one low", 8'h00, byte_t'(poweredDown));
		@(posedge ref_clk);
		negNearGnd <= 1'b1;
		cyc(8);
		chk("dis end", 8'h00, byte_t'(dischargeOn));
		chk("pwr down", 8'h01, byte_t'(poweredDown));
		@(posedge ref_clk);
		shutdownReq <= 1'b0;
		posNearGnd <= 1'b0;
		negNearGnd <= 1'b0;
		cyc(8);
		chk("restart", 8'h01, byte_t'(convEnable));
		wr(`ADDR_BYTE2, 8'h30);
		@(posedge ref_clk);
		shutdownReq <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(negedge ref_clk);
			chk("no dis", 8'h00, byte_t'(dischargeOn));
		end
		chk("off now", 8'h01, byte_t'(poweredDown));
		@(posedge ref_clk);
		shutdownReq <= 1'b0;
		cyc(8);
		$display("discharge test done");
	endtask

	task automatic testLock();
		hostOp(REQ_PROGRAM, `ADDR_BYTE2, 8'h40);
		chk("lock fault", 8'h00, byte_t'(rspFault));
		chk("locked", 8'h01, byte_t'(locked));
		wr(`ADDR_BYTE2, 8'h30);
		wr(`ADDR_CMD, 8'h14);
		rdChk("lock rd", `ADDR_BYTE2, 8'h40);
		chk("cfg2 nv", 8'h40, cfgByte2);
		wr(`ADDR_BYTE0, 8'h11);
		wr(`ADDR_CMD, 8'h11);
		chk("cfg0 nv", 8'h5A, cfgByte0);
		rdChk("byte0 rd", `ADDR_BYTE0, 8'h5A);
		hostOp(REQ_PROGRAM, `ADDR_BYTE0, 8'hA5);
		chk("lock prog", 8'h01, byte_t'(rspFault));
		wr(`ADDR_CMD, `CMD_SWITCH_OFF_ONLY);
		chk("nv kept", 8'h5A, cfgByte0);
		rdChk("fault held", `ADDR_CMD, 8'h50);
		wr(`ADDR_CMD, `CMD_CLEAR_OFF);
		rdChk("fault clr", `ADDR_CMD, 8'h10);
		rdChk("lock again", `ADDR_BYTE2, 8'h40);
		$display("lock test done");
	endtask

	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		cyc(4);
		testCommands();
		testProgram();
		testDischarge();
		testLock();
		finalReport();
	end
endmodule

// *** testbench/otp_link_chk.sv ***
// assertions on the register link between host and device ends
// assumes the bench top instantiates it beside otp_link_if
`timescale 1ns/100ps
`include "otp_ctrl_cfg.svh"
module otp_link_chk
	import otp_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// link signals
	input wire logic regWr,
	input wire logic regRd,
	input wire byte_t regAddr,
	input wire byte_t regWdata,
	input wire byte_t regRdata,
	input wire logic regAck,
	input wire logic shutdownN,
	input wire logic vppOn
);
	// ----------------------------------------------------------------
	// link history
	// ----------------------------------------------------------------
	logic lockSeen_ff;
	logic faultDue_ff;
	logic faultClr_ff;
	logic rdByte2_ff;
	byte_t cmdWr_ff;
	wire cmdWrite = regWr && regAddr == `ADDR_CMD;
	wire progStart = cmdWrite && regWdata[7] && !cmdWr_ff[7];
	wire clrWrite = cmdWrite && regWdata[6] && !progStart;
	wire lockRead = regAck && rdByte2_ff && regRdata[6];
	wire nxt_lockSeen = lockSeen_ff || lockRead;
	wire nxt_faultDue = progStart ? (lockSeen_ff || !vppOn) :
		(faultDue_ff && !clrWrite);
	wire nxt_faultClr = !progStart && (faultClr_ff || clrWrite);
	wire nxt_rdByte2 = regRd && regAddr == `ADDR_BYTE2;
	wire byte_t nxt_cmdWr = cmdWrite ? regWdata : cmdWr_ff;

	always_ff @(posedge ref_clk) begin
		lockSeen_ff <= !sys_rst && nxt_lockSeen;
		faultDue_ff <= !sys_rst && nxt_faultDue;
		faultClr_ff <= !sys_rst && nxt_faultClr;
		rdByte2_ff <= !sys_rst && nxt_rdByte2;
		cmdWr_ff <= sys_rst ? `CMD_RUN : nxt_cmdWr;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence anyReq;
		regWr || regRd;
	endsequence
	sequence cmdRead;
		regRd && regAddr == `ADDR_CMD;
	endsequence

	chk_ack_follows: assert property (anyReq |=> regAck)
		else $error("request not acknowledged");
	chk_ack_caused: assert property (regAck |-> $past(regWr || regRd))
		else $error("acknowledge without request");
	chk_ack_pulse: assert property (regAck |=> !regAck)
		else $error("acknowledge too long");
	chk_unmapped_zero: assert property (regRd && regAddr > `ADDR_BYTE2
		&& regAddr != `ADDR_CMD |=> regRdata == `NV_BLANK)
		else $error("unmapped read not zero");
	chk_switch_off_readback: assert property (cmdRead |=>
		regRdata[`CMD_SWITCH_OFF_BIT] == cmdWr_ff[`CMD_SWITCH_OFF_BIT])
		else $error("switch-off readback wrong");
	chk_fault_clear: assert property (cmdRead ##0 faultClr_ff
		|=> !regRdata[`CMD_FAULT_BIT])
		else $error("fault not cleared");
	chk_fault_held: assert property (cmdRead ##0 faultDue_ff
		|=> regRdata[`CMD_FAULT_BIT])
		else $error("fault not reported");
	chk_lock_stays: assert property (regRd && regAddr == `ADDR_BYTE2
		&& lockSeen_ff |=> regRdata[`CFG_LOCK_BIT])
		else $error("lock bit lost");
	chk_supply_first: assert property (progStart |-> vppOn)
		else $error("programming started without supply");
endmodule
